// ---- hdl/fid_pkg.sv ----
// Constants, register layout and carrier types of the field interrupt detector
package fid_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CFG2    = 8'h02;
    localparam logic [7:0]  ADDR_CFG3    = 8'h03;
    localparam logic [7:0]  ADDR_PWR     = 8'h27;
    localparam logic [7:0]  ADDR_MEAS    = 8'h28;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          LATCH_BIT    = 5;
    localparam int          HALL_LO      = 19;
    localparam int          NV_EN_BIT    = 21;
    localparam int          NV_ST_BIT    = 22;
    localparam int          MODE_BIT     = 23;
    localparam int          IEN_LO       = 24;
    localparam int          SGN_BIT      = 27;
    localparam int          THR_W        = 6;
    localparam int          MEAS_INT_BIT = 6;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  HALL_OUTER   = 2'h2;
    localparam logic [1:0]  PWR_DUTY     = 2'h2;
    localparam logic [31:0] CFG2_RST     = 32'h00000000;
    localparam logic [31:0] CFG3_RST     = 32'h00000000;
    localparam logic [31:0] PWR_RST      = 32'h00000000;
    localparam int          UNS_SHIFT    = 5;
    localparam int          SGN_SHIFT    = 6;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic signed [11:0] fid_samp_t;

    typedef struct packed {
        fid_samp_t x;
        fid_samp_t y;
        fid_samp_t z;
    } fid_axes_t;

    typedef struct packed {
        fid_samp_t xi;
        fid_samp_t yi;
        fid_samp_t zi;
        fid_samp_t xe;
        fid_samp_t xw;
        fid_samp_t yn;
        fid_samp_t ys;
    } fid_raw_t;

    typedef struct packed {
        logic [31:0] cfg2;
        logic [31:0] cfg3;
        logic [31:0] pwr;
        fid_axes_t   meas;
        fid_axes_t   base;
        logic [2:0]  hits;
        logic        intAct;
        logic        intN;
        logic        nvReq;
        logic        lpPrev;
        logic [31:0] rd;
    } fid_state_t;

endpackage : fid_pkg

// ---- hdl/fid_detector.sv ----
// Field interrupt detector: source select, per-axis compare, pin and status
// Operation
// - Two-bit source field: 0 inner elements, 2 summed outer, 1 reserved.
// - Outer selection: X is east plus west, Y north plus south, Z inner.
// - Each axis has its own interrupt enable; disabled axes never trigger.
// - An event drives the low-active pin and sets the measurement status bit.
// - Latch enabled: pin and status stay asserted after the field subsides.
// - Latch disabled: pin and status release once the condition stops holding.
// - Non-volatile enable set: a detected event writes a non-volatile status bit.
// - Mode bit: 0 absolute threshold compare, 1 change from baseline.
// - Threshold scheme: enabled channel triggers when sample reaches its threshold.
// - Change scheme: last sample stored as baseline on entering duty-cycled mode.
// - Change scheme: each active phase compares new data to baseline against delta.
// - Three shared six-bit fields serve as thresholds or deltas per scheme.
// - Signed bit clear: unsigned level, absolute sample compared, both polarities.
// - Signed bit set: signed level, only one polarity can trigger.
// - Unsigned level is field plus one, times thirty-two, minus one.
// - Signed level is (field plus one) times sixty-four, minus one if non-negative.
// - Power field value 2 selects duty-cycled low-power operation.
`timescale 1ns/1ps

module fid_detector (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            regWr,
    input  wire logic            regRd,
    input  wire logic [7:0]      regAddr,
    input  wire logic [31:0]     regWrData,
    input  wire logic            sampleValid,
    input  wire logic            activeStart,
    input  wire fid_pkg::fid_raw_t raw,
    output logic      [31:0]     regRdData,
    output logic                 intN,
    output logic                 nvWrReq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic fid_pkg::fid_samp_t fidSat(input logic signed [12:0] s);
        if (s > 13'sh07ff) begin
            fidSat = 12'sh7ff;
        end else if (s < -13'sh0800) begin
            fidSat = -12'sh800;
        end else begin
            fidSat = s[11:0];
        end
    endfunction : fidSat

    function automatic logic signed [13:0] fidLevel(input logic [5:0] t,
                                                    input logic       sgn);
        logic signed [13:0] tx;
        tx = sgn ? 14'(signed'(t)) : 14'({8'h00, t});
        if (!sgn) begin
            fidLevel = ((tx + 14'sh1) <<< fid_pkg::UNS_SHIFT) - 14'sh1;
        end else if (!tx[13]) begin
            fidLevel = ((tx + 14'sh1) <<< fid_pkg::SGN_SHIFT) - 14'sh1;
        end else begin
            fidLevel = (tx + 14'sh1) <<< fid_pkg::SGN_SHIFT;
        end
    endfunction : fidLevel

    function automatic logic fidHit(input logic signed [13:0] v,
                                    input logic [5:0]         t,
                                    input logic               sgn);
        logic signed [13:0] lv;
        logic signed [13:0] av;
        lv = fidLevel(t, sgn);
        av = v[13] ? -v : v;
        if (!sgn) begin
            fidHit = av >= lv;
        end else if (!t[5]) begin
            fidHit = v >= lv;
        end else begin
            fidHit = v <= lv;
        end
    endfunction : fidHit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fid_pkg::fid_state_t st;
    fid_pkg::fid_state_t nx;

    logic              latchEn;
    logic              nvEn;
    logic              deltaMode;
    logic              sgnEn;
    logic [2:0]        axisEn;
    logic [1:0]        hallSel;
    logic              lpNow;
    logic              evalNow;
    logic              clrReq;
    logic              cond;
    fid_pkg::fid_axes_t newS;
    logic [2:0]        newHits;

    assign latchEn   = st.cfg2[fid_pkg::LATCH_BIT];
    assign hallSel   = st.cfg2[fid_pkg::HALL_LO +: 2];
    assign nvEn      = st.cfg3[fid_pkg::NV_EN_BIT];
    assign deltaMode = st.cfg3[fid_pkg::MODE_BIT];
    assign sgnEn     = st.cfg3[fid_pkg::SGN_BIT];
    assign axisEn    = st.cfg3[fid_pkg::IEN_LO +: 3];
    assign lpNow     = st.pwr[1:0] == fid_pkg::PWR_DUTY;
    assign clrReq    = regWr && (regAddr == fid_pkg::ADDR_MEAS);

    // ------------------------------------------------------------------
    // Source select and comparison
    // ------------------------------------------------------------------
    always_comb begin
        newS.z = raw.zi;
        if (hallSel == fid_pkg::HALL_OUTER) begin
            newS.x = fidSat(13'(raw.xe) + 13'(raw.xw));
            newS.y = fidSat(13'(raw.yn) + 13'(raw.ys));
        end else begin
            newS.x = raw.xi;
            newS.y = raw.yi;
        end
    end

    // Change scheme only evaluates at the start of an active phase
    assign evalNow = sampleValid && (!deltaMode || (lpNow && activeStart));

    always_comb begin
        logic signed [13:0] vx;
        logic signed [13:0] vy;
        logic signed [13:0] vz;
        vx = 14'(newS.x);
        vy = 14'(newS.y);
        vz = 14'(newS.z);
        if (deltaMode) begin
            vx = 14'(newS.x) - 14'(st.base.x);
            vy = 14'(newS.y) - 14'(st.base.y);
            vz = 14'(newS.z) - 14'(st.base.z);
        end
        newHits[0] = fidHit(vx, st.cfg3[0 +: fid_pkg::THR_W], sgnEn);
        newHits[1] = fidHit(vy, st.cfg3[6 +: fid_pkg::THR_W], sgnEn);
        newHits[2] = fidHit(vz, st.cfg3[12 +: fid_pkg::THR_W], sgnEn);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nx       = st;
        nx.nvReq = 1'b0;
        nx.lpPrev = lpNow;
        cond     = 1'b0;
        if (regWr) begin
            case (regAddr)
                fid_pkg::ADDR_CFG2: begin
                    nx.cfg2 = regWrData;
                end
                fid_pkg::ADDR_CFG3: begin
                    nx.cfg3 = regWrData;
                end
                fid_pkg::ADDR_PWR: begin
                    nx.pwr = regWrData;
                end
                default: begin
                    nx.cfg2 = st.cfg2;
                end
            endcase
        end
        if (lpNow && !st.lpPrev) begin
            nx.base = st.meas;
        end
        if (sampleValid) begin
            nx.meas = newS;
        end
        if (evalNow) begin
            nx.hits = newHits;
        end
        cond = |(nx.hits & axisEn);
        // A fresh event wins over a clear in the same cycle
        nx.intAct = cond || (st.intAct && latchEn && !clrReq);
        nx.intN   = !nx.intAct;
        if (nx.intAct && !st.intAct && nvEn) begin
            nx.cfg3[fid_pkg::NV_ST_BIT] = 1'b1;
            nx.nvReq = 1'b1;
        end
        if (regRd) begin
            case (regAddr)
                fid_pkg::ADDR_CFG2: begin
                    nx.rd = st.cfg2;
                end
                fid_pkg::ADDR_CFG3: begin
                    nx.rd = st.cfg3;
                end
                fid_pkg::ADDR_PWR: begin
                    nx.rd = st.pwr;
                end
                fid_pkg::ADDR_MEAS: begin
                    nx.rd = {st.meas.x[11:4], st.meas.y[11:4], st.meas.z[11:4], 8'h00};
                    nx.rd[fid_pkg::MEAS_INT_BIT] = st.intAct;
                end
                default: begin
                    nx.rd = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st        <= '0;
            st.cfg2   <= fid_pkg::CFG2_RST;
            st.cfg3   <= fid_pkg::CFG3_RST;
            st.pwr    <= fid_pkg::PWR_RST;
            st.intN   <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    assign regRdData = st.rd;
    assign intN      = st.intN;
    assign nvWrReq   = st.nvReq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence sEvalHit;
        evalNow && |(newHits & axisEn);
    endsequence

    sequence sEvalQuiet;
        evalNow && !(|(newHits & axisEn)) && !latchEn;
    endsequence

    a_inner_select: assert property (
        sampleValid && hallSel != fid_pkg::HALL_OUTER |=> st.meas.x == $past(raw.xi)
    ) else $error("inner source not reported");

    a_outer_sum: assert property (
        sampleValid && hallSel == fid_pkg::HALL_OUTER
        |=> st.meas.x == fidSat(13'($past(raw.xe)) + 13'($past(raw.xw)))
            && st.meas.z == $past(raw.zi)
    ) else $error("outer sum wrong");

    a_axis_masked: assert property (
        axisEn == 3'h0 && intN && !regWr |=> intN
    ) else $error("disabled axes raised interrupt");

    a_event_pin: assert property (
        (sEvalHit and !regWr) ##1 (regRd && regAddr == fid_pkg::ADDR_MEAS && !sampleValid)
        |=> !intN && regRdData[fid_pkg::MEAS_INT_BIT]
    ) else $error("event not reported on pin and status");

    a_latch_hold: assert property (
        !intN && latchEn && !clrReq && !regWr |=> !intN [*1] ##0 st.intAct
    ) else $error("latched interrupt released");

    a_unlatch_free: assert property (
        sEvalQuiet and !regWr |=> intN
    ) else $error("unlatched interrupt not released");

    a_nv_record: assert property (
        $fell(intN) && $past(nvEn) |-> nvWrReq && st.cfg3[fid_pkg::NV_ST_BIT]
    ) else $error("event not recorded in non-volatile status");

    a_delta_gate: assert property (
        deltaMode && sampleValid && !activeStart && !regWr |=> st.hits == $past(st.hits)
    ) else $error("change scheme evaluated outside active phase");

    a_base_store: assert property (
        lpNow && !st.lpPrev |=> st.base == $past(st.meas)
    ) else $error("baseline not stored");

    a_level_unsigned: assert property (
        fidLevel(6'h00, 1'b0) == 14'sh001f && fidLevel(6'h3f, 1'b0) == 14'sh07ff
    ) else $error("unsigned level wrong");

    a_level_signed: assert property (
        fidLevel(6'h00, 1'b1) == 14'sh003f && fidLevel(6'h3f, 1'b1) == 14'sh0000
    ) else $error("signed level wrong");

    a_thr_eval: assert property (
        !deltaMode && sampleValid |=> st.hits == $past(newHits)
    ) else $error("threshold sample not evaluated");

    a_unsigned_hit: assert property (
        evalNow && !deltaMode && !sgnEn && st.cfg3[0 +: fid_pkg::THR_W] == 6'h00
        && newS.x >= 12'sd31 |=> st.hits[0]
    ) else $error("unsigned threshold missed");

    a_abs_negative: assert property (
        evalNow && !deltaMode && !sgnEn && st.cfg3[0 +: fid_pkg::THR_W] == 6'h00
        && newS.x <= -12'sd31 |=> st.hits[0]
    ) else $error("negative field missed in unsigned scheme");

    a_signed_pos: assert property (
        evalNow && !deltaMode && sgnEn && st.cfg3[0 +: fid_pkg::THR_W] == 6'h00
        && newS.x < 12'sd0 |=> !st.hits[0]
    ) else $error("positive signed level hit by negative field");

    a_signed_neg: assert property (
        evalNow && !deltaMode && sgnEn && st.cfg3[0 +: fid_pkg::THR_W] == 6'h3f
        && newS.x > 12'sd0 |=> !st.hits[0]
    ) else $error("negative signed level hit by positive field");

    a_duty_enter: assert property (
        regWr && regAddr == fid_pkg::ADDR_PWR && regWrData[1:0] == fid_pkg::PWR_DUTY
        |=> lpNow
    ) else $error("duty-cycled operation not entered");

    a_or_combine: assert property (
        evalNow && !latchEn
        |=> st.intAct == (|($past(newHits) & $past(axisEn)))
    ) else $error("interrupt condition is not the OR of axes");

    a_hits_hold: assert property (
        !evalNow |=> st.hits == $past(st.hits)
    ) else $error("results changed without evaluation");

    a_status_read: assert property (
        regRd && regAddr == fid_pkg::ADDR_MEAS
        |=> regRdData[fid_pkg::MEAS_INT_BIT] == !$past(intN)
    ) else $error("status bit differs from pin");

    a_nv_pulse: assert property (
        nvWrReq |=> !nvWrReq
    ) else $error("non-volatile request longer than one cycle");

    a_inner_yz: assert property (
        sampleValid && hallSel != fid_pkg::HALL_OUTER
        |=> st.meas.y == $past(raw.yi) && st.meas.z == $past(raw.zi)
    ) else $error("inner Y or Z not reported");

    a_outer_y: assert property (
        sampleValid && hallSel == fid_pkg::HALL_OUTER
        |=> st.meas.y == fidSat(13'($past(raw.yn)) + 13'($past(raw.ys)))
    ) else $error("outer Y sum wrong");

    a_base_hold: assert property (
        !(lpNow && !st.lpPrev) |=> st.base == $past(st.base)
    ) else $error("baseline changed outside entry");

endmodule : fid_detector

// ---- tb/fid_host_model.sv ----
// Host model that counts interrupt pin assertions and non-volatile write requests
`timescale 1ns/1ps

module fid_host_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       intN,
    input  wire logic       nvWrReq,
    output logic      [7:0] irqCnt_ff,
    output logic      [7:0] nvCnt_ff
);
    logic intPrev_ff;

    // Host counts each falling edge of the low-active pin as one interrupt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intPrev_ff <= 1'b1;
            irqCnt_ff  <= 8'h00;
            nvCnt_ff   <= 8'h00;
        end else begin
            intPrev_ff <= intN;
            if (intPrev_ff && !intN) begin
                irqCnt_ff <= irqCnt_ff + 8'h01;
            end
            if (nvWrReq) begin
                nvCnt_ff <= nvCnt_ff + 8'h01;
            end
        end
    end
endmodule : fid_host_model

// ---- tb/tb_field_interrupt_detector.sv ----
// Self-checking testbench of the field interrupt detector
`timescale 1ns/1ps

module tb_field_interrupt_detector;
    logic               clk = 1'b0;
    logic               resetn = 1'b0;
    logic               regWr = 1'b0;
    logic               regRd = 1'b0;
    logic [7:0]         regAddr = 8'h00;
    logic [31:0]        regWrData = 32'h0;
    logic               sampleValid = 1'b0;
    logic               activeStart = 1'b0;
    fid_pkg::fid_raw_t  raw = '0;
    logic [31:0]        regRdData;
    logic               intN;
    logic               nvWrReq;
    logic [7:0]         irqCnt;
    logic [7:0]         nvCnt;
    int                 errorCnt = 0;
    int                 nChecks = 0;

    always #2.5 clk = ~clk;

    fid_detector fid_detector_inst (.clk(clk), .resetn(resetn), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regWrData(regWrData), .sampleValid(sampleValid),
        .activeStart(activeStart), .raw(raw), .regRdData(regRdData), .intN(intN),
        .nvWrReq(nvWrReq));

    fid_host_model fid_host_model_inst (.clk(clk), .resetn(resetn), .intN(intN),
        .nvWrReq(nvWrReq), .irqCnt_ff(irqCnt), .nvCnt_ff(nvCnt));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        @(posedge clk);
        #1;
        chk("regRdData", regRdData, exp);
    endtask : rd

    // Pin is judged just after the edge that takes the sample
    task automatic samp(input logic signed [11:0] x, input logic signed [11:0] y,
                        input logic act, input logic expN);
        @(posedge clk);
        raw.xi      <= x;
        raw.yi      <= y;
        sampleValid <= 1'b1;
        activeStart <= act;
        @(posedge clk);
        sampleValid <= 1'b0;
        activeStart <= 1'b0;
        #1;
        chk("intN", {31'h0, intN}, {31'h0, expN});
    endtask : samp

    task automatic endSim;
        $display("checks %0d errors %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : endSim

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk("intN", {31'h0, intN}, 32'h1);
        rd(fid_pkg::ADDR_CFG2, 32'h0);
        rd(fid_pkg::ADDR_CFG3, 32'h0);
        rd(fid_pkg::ADDR_PWR, 32'h0);
        wr(8'h10, 32'hffffffff);
        rd(8'h10, 32'h0);
    endtask : t_reset

    task automatic t_unsigned;
        wr(fid_pkg::ADDR_CFG3, 32'h06001080);
        samp(12'sd0, 12'sd94, 1'b0, 1'b1);
        samp(12'sd2000, 12'sd95, 1'b0, 1'b0);
        raw.zi <= 12'sd62;
        samp(12'sd0, 12'sd0, 1'b0, 1'b1);
        raw.zi <= 12'sd63;
        samp(12'sd0, 12'sd0, 1'b0, 1'b0);
        raw.zi <= 12'sd0;
        wr(fid_pkg::ADDR_CFG3, 32'h01000001);
        samp(12'sd63, 12'sd0, 1'b0, 1'b0);
        samp(12'sd62, 12'sd0, 1'b0, 1'b1);
        samp(-12'sd63, 12'sd0, 1'b0, 1'b0);
        samp(12'sd0, 12'sd2000, 1'b0, 1'b1);
    endtask : t_unsigned

    task automatic t_latched;
        wr(fid_pkg::ADDR_CFG2, 32'h00000020);
        samp(12'sd63, 12'sd0, 1'b0, 1'b0);
        samp(12'sd0, 12'sd0, 1'b0, 1'b0);
        rd(fid_pkg::ADDR_MEAS, 32'h00000040);
        wr(fid_pkg::ADDR_MEAS, 32'h0);
        #1;
        chk("intN", {31'h0, intN}, 32'h1);
        rd(fid_pkg::ADDR_MEAS, 32'h0);
        // Read of the status in the cycle right after the hit
        @(posedge clk);
        raw.xi      <= 12'sd64;
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        regRd       <= 1'b1;
        regAddr     <= fid_pkg::ADDR_MEAS;
        @(posedge clk);
        regRd       <= 1'b0;
        #1;
        chk("regRdData", regRdData, 32'h04000040);
        wr(fid_pkg::ADDR_CFG2, 32'h0);
    endtask : t_latched

    task automatic t_signed;
        wr(fid_pkg::ADDR_CFG3, 32'h09000001);
        samp(12'sd126, 12'sd0, 1'b0, 1'b1);
        samp(12'sd127, 12'sd0, 1'b0, 1'b0);
        samp(-12'sd200, 12'sd0, 1'b0, 1'b1);
        wr(fid_pkg::ADDR_CFG3, 32'h0900003e);
        samp(-12'sd64, 12'sd0, 1'b0, 1'b0);
        samp(-12'sd63, 12'sd0, 1'b0, 1'b1);
    endtask : t_signed

    task automatic t_outer;
        wr(fid_pkg::ADDR_CFG2, 32'h00100000);
        wr(fid_pkg::ADDR_CFG3, 32'h01200001);
        raw.xe <= 12'sd40;
        raw.xw <= 12'sd30;
        raw.yn <= 12'sh010;
        raw.ys <= 12'sh020;
        raw.zi <= 12'sh150;
        samp(12'sd0, 12'sd0, 1'b0, 1'b0);
        chk("nvWrReq", {31'h0, nvWrReq}, 32'h1);
        rd(fid_pkg::ADDR_MEAS, 32'h04031540);
        rd(fid_pkg::ADDR_CFG3, 32'h01600001);
        wr(fid_pkg::ADDR_CFG2, 32'h00080000);
        samp(12'sd0, 12'sd0, 1'b0, 1'b1);
    endtask : t_outer

    task automatic t_delta;
        wr(fid_pkg::ADDR_CFG2, 32'h0);
        wr(fid_pkg::ADDR_CFG3, 32'h01800001);
        samp(12'sd100, 12'sd0, 1'b0, 1'b1);
        wr(fid_pkg::ADDR_PWR, 32'h00000002);
        rd(fid_pkg::ADDR_PWR, 32'h00000002);
        samp(12'sd160, 12'sd0, 1'b1, 1'b1);
        samp(12'sd163, 12'sd0, 1'b0, 1'b1);
        samp(12'sd163, 12'sd0, 1'b1, 1'b0);
        samp(12'sd100, 12'sd0, 1'b1, 1'b1);
    endtask : t_delta

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_unsigned();
        t_latched();
        t_signed();
        t_outer();
        t_delta();
        repeat (2) @(posedge clk);
        #1;
        chk("irqCnt", {24'h0, irqCnt}, 32'ha);
        chk("nvCnt", {24'h0, nvCnt}, 32'h1);
        endSim();
    end

    initial begin
        #20000;
        errorCnt++;
        endSim();
    end
endmodule : tb_field_interrupt_detector
